/* ovl_recovery_pkg.sv */
package ovl_recovery_pkg;
	// Quantizer code layout, offset binary
	localparam int QCODE_W = 5;
	localparam logic [QCODE_W-1:0] FS_POS_CODE = 5'h1F;
	localparam logic [QCODE_W-1:0] FS_NEG_CODE = 5'h00;
	// Sliding window of full-scale hits
	localparam int WIN_LEN = 8;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] WIN_LIMIT = 4'h5;
	// Recovery sequence lengths in modulator clock cycles
	localparam int SEQ_CNT_W = 6;
	localparam logic [SEQ_CNT_W-1:0] RESET_CYCLES = 6'h10;
	localparam logic [SEQ_CNT_W-1:0] RAMP_CYCLES = 6'h30;
	// One bit wider than the sequence counter, since 64 does not fit in it
	localparam logic [SEQ_CNT_W:0] VALID_CYCLES = 7'h40;
	// Ramp steps down by one dB every two to the power of this many cycles (eight)
	localparam int RAMP_STEP_SHIFT = 3;
	// Attenuation widths and boost
	localparam int PROG_W = 5;
	localparam int ATT_W = 6;
	localparam logic [ATT_W-1:0] ATT_BOOST_DB = 6'h06;
	// Decimation flush lengths, output samples held per filter memory
	localparam int DSEL_W = 2;
	localparam int FLUSH_W = 12;
	localparam logic [FLUSH_W-1:0] FLUSH_TAPS = 12'h040;
	localparam logic [FLUSH_W-1:0] DEC_FACTOR_0 = 12'h00C;
	localparam logic [FLUSH_W-1:0] DEC_FACTOR_1 = 12'h010;
	localparam logic [FLUSH_W-1:0] DEC_FACTOR_2 = 12'h018;
	localparam logic [FLUSH_W-1:0] DEC_FACTOR_3 = 12'h020;
	// Reset values
	localparam logic [CNT_W-1:0] CNT_RESET = 4'h0;
	localparam logic [WIN_LEN-1:0] HIST_RESET = 8'h00;

	// Recovery sequencer states
	typedef enum logic [1:0] {st_idle, st_reset, st_ramp} seq_state_e;
endpackage

/* fs_window_if.sv */
`timescale 1ns/1ps
interface fs_window_if;
	import ovl_recovery_pkg::*;
	logic [QCODE_W-1:0] code; // Quantizer code of this cycle
	logic clear; // Empties the window while the loop is held in reset
	logic overload; // More than the limit of full-scale hits in the window
	logic [CNT_W-1:0] count; // Full-scale hits currently in the window

	// Window side
	modport window
	(
		input code,
		input clear,
		output overload,
		output count
	);
	// Sequencer side
	modport sequencer
	(
		output code,
		output clear,
		input overload,
		input count
	);
endinterface

/* fs_window.sv */
`timescale 1ns/1ps
module fs_window
	import ovl_recovery_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// Window link
	fs_window_if.window win
);
	////////////////////////////////////////////////////////////////////////
	// History of full-scale flags, newest in bit 0
	logic [WIN_LEN-1:0] hist;
	logic hit; // Current code sits at either full-scale end
	logic [WIN_LEN-1:0] next_hist;
	logic [CNT_W-1:0] next_count;

	// Count of set bits in the history
	function automatic logic [CNT_W-1:0] ones(input logic [WIN_LEN-1:0] v);
		logic [CNT_W-1:0] n;
		n = CNT_RESET;
		for (int i = 0; i < WIN_LEN; i++)
		begin
			n = n + {{(CNT_W-1){1'b0}}, v[i]};
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Full-scale test on both ends of the code range
	always_comb
	begin
		hit = (win.code == FS_POS_CODE) || (win.code == FS_NEG_CODE); // (R1)
		next_hist = {hist[WIN_LEN-2:0], hit}; // (R10)
		next_count = ones(next_hist);
	end

	// Window slides every cycle; clearing drops all history
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in || win.clear)
		begin
			hist <= HIST_RESET; // (R10)
		end
		else
		begin
			hist <= next_hist; // (R10)
		end
	end

	// Count and overload flag registered so the sequencer sees clean levels
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in || win.clear)
		begin
			win.count <= CNT_RESET;
			win.overload <= 1'b0;
		end
		else
		begin
			win.count <= next_count;
			win.overload <= next_count > WIN_LIMIT; // (R2)
		end
	end
endmodule

/* sigma_delta_overload_recovery.sv */
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Five-bit codes; extremes count as full scale
// (R2) Overload when over five of eight full-scale
// (R3) Overload asserts modulator reset, zeroing loop state
// (R4) Overload raises attenuation six dB above programmed
// (R5) Reset held sixteen cycles, then released
// (R6) Attenuation ramps back over forty-eight cycles
// (R7) Renewed overload reruns the whole sequence
// (R8) Samples valid within sixty-four cycles after
// (R9) Decimated output affected until filters flushed
// (R10) Window slides each cycle, cleared during reset
module sigma_delta_overload_recovery
	import ovl_recovery_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// Modulator quantizer
	input wire logic [QCODE_W-1:0] quant_code_in,
	// Programmed settings
	input wire logic [PROG_W-1:0] atten_prog_in,
	input wire logic [DSEL_W-1:0] decimation_factor_select_in,
	// Modulator control
	output logic mod_reset_out,
	output logic [ATT_W-1:0] atten_out,
	// Status
	output logic overload_event_out,
	output logic samples_valid_out,
	output logic decim_affected_out,
	output logic [CNT_W-1:0] window_count_out
);
	////////////////////////////////////////////////////////////////////////
	// Declarations
	fs_window_if win(); // Link to the sliding window
	seq_state_e state; // Recovery sequencer state
	seq_state_e next_state;
	logic [SEQ_CNT_W-1:0] seq_cnt; // Cycles spent in the current state
	logic [SEQ_CNT_W-1:0] next_seq_cnt;
	logic [ATT_W-1:0] boost; // Extra attenuation now applied
	logic [ATT_W-1:0] next_boost;
	logic declare; // Overload accepted this cycle
	logic seq_done; // Ramp finishes this cycle
	logic [FLUSH_W-1:0] flush_cnt; // Cycles left until filters are clean
	logic [FLUSH_W-1:0] next_flush_cnt;

	// Flush length in modulator cycles for a decimation choice
	function automatic logic [FLUSH_W-1:0] flush_cycles(input logic [DSEL_W-1:0] sel);
		logic [FLUSH_W-1:0] f;
		f = DEC_FACTOR_0;
		case (sel)
			2'h0: f = DEC_FACTOR_0;
			2'h1: f = DEC_FACTOR_1;
			2'h2: f = DEC_FACTOR_2;
			default: f = DEC_FACTOR_3;
		endcase
		// Product is at most 2048, well inside the count width
		return FLUSH_W'(f * FLUSH_TAPS);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sliding full-scale window
	fs_window u_window
	(
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.win(win.window)
	);

	// Window input and clear; clearing follows the registered reset so the
	// window starts empty on the first good sample after release
	always_comb
	begin
		win.code = quant_code_in;
		win.clear = mod_reset_out; // (R10)
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer next state
	always_comb
	begin
		next_state = state;
		next_seq_cnt = seq_cnt;
		declare = 1'b0;
		seq_done = 1'b0;
		case (state)
			st_idle:
			begin
				// Wait for the window to call overload
				if (win.overload)
				begin
					declare = 1'b1;
					next_state = st_reset; // (R3)
					next_seq_cnt = '0;
				end
			end
			st_reset:
			begin
				// Window is cleared here, so no detection can interrupt
				if (seq_cnt == RESET_CYCLES - 6'h01)
				begin
					next_state = st_ramp; // (R5)
					next_seq_cnt = '0;
				end
				else
				begin
					next_seq_cnt = seq_cnt + 6'h01;
				end
			end
			st_ramp:
			begin
				if (win.overload)
				begin
					// Overload during the ramp restarts from the reset
					declare = 1'b1;
					next_state = st_reset; // (R7)
					next_seq_cnt = '0;
				end
				else if (seq_cnt == RAMP_CYCLES - 6'h01)
				begin
					seq_done = 1'b1;
					next_state = st_idle; // (R6)
					next_seq_cnt = '0;
				end
				else
				begin
					next_seq_cnt = seq_cnt + 6'h01;
				end
			end
			default:
			begin
				next_state = st_idle;
				next_seq_cnt = '0;
			end
		endcase
	end

	// Extra attenuation: full boost in reset, one dB lower every eight ramp
	// cycles; the ramp is stepwise since the attenuator has 1 dB steps
	always_comb
	begin
		next_boost = '0;
		if (next_state == st_reset)
		begin
			next_boost = ATT_BOOST_DB; // (R4)
		end
		else if (next_state == st_ramp)
		begin
			next_boost = ATT_BOOST_DB - ATT_W'(next_seq_cnt >> RAMP_STEP_SHIFT); // (R6)
		end
	end

	// Flush countdown starts as the sequence ends
	always_comb
	begin
		next_flush_cnt = flush_cnt;
		if (declare)
		begin
			next_flush_cnt = '0;
		end
		else if (seq_done)
		begin
			next_flush_cnt = flush_cycles(decimation_factor_select_in); // (R9)
		end
		else if (flush_cnt != '0)
		begin
			next_flush_cnt = flush_cnt - 12'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer state and counters
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			state <= st_idle;
			seq_cnt <= '0;
			boost <= '0;
			flush_cnt <= '0;
		end
		else
		begin
			state <= next_state;
			seq_cnt <= next_seq_cnt;
			boost <= next_boost;
			flush_cnt <= next_flush_cnt;
		end
	end

	// Modulator reset and attenuation, registered from next values so they
	// change on the same edge as the state
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			mod_reset_out <= 1'b0;
			atten_out <= '0;
		end
		else
		begin
			mod_reset_out <= next_state == st_reset; // (R3)
			// Boost rides on the live programmed value
			atten_out <= {1'b0, atten_prog_in} + next_boost; // (R4)
		end
	end

	// Status: validity returns when reset plus ramp (64 cycles) are over;
	// the decimated output stays flagged until the flush count runs out
	always_ff @(posedge core_clk_in)
	begin
		if (reset_in)
		begin
			overload_event_out <= 1'b0;
			samples_valid_out <= 1'b1;
			decim_affected_out <= 1'b0;
			window_count_out <= '0;
		end
		else
		begin
			overload_event_out <= declare; // (R7)
			samples_valid_out <= next_state == st_idle; // (R8)
			decim_affected_out <= (next_state != st_idle) || (next_flush_cnt != '0); // (R9)
			window_count_out <= win.count;
		end
	end
endmodule

/* sdor_monitor.sv */
`timescale 1ns/1ps
module sdor_monitor
	import ovl_recovery_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// Inputs
	input wire logic [QCODE_W-1:0] quant_code_in,
	input wire logic [PROG_W-1:0] atten_prog_in,
	input wire logic [DSEL_W-1:0] decimation_factor_select_in,
	// Outputs
	input wire logic mod_reset_out,
	input wire logic [ATT_W-1:0] atten_out,
	input wire logic overload_event_out,
	input wire logic samples_valid_out,
	input wire logic decim_affected_out,
	input wire logic [CNT_W-1:0] window_count_out
);
default clocking @(posedge core_clk_in); endclocking
default disable iff (reset_in);
logic [6:0] held; // Cycles the loop reset has stood
logic [6:0] since; // Cycles since the last declaration, saturating
////////////////////////////////////////////////////////////////////////////////
// Counts the loop reset length; it never exceeds sixteen, so no saturation
always_ff @(posedge core_clk_in)
	held <= (mod_reset_out && !reset_in) ? held + 7'h01 : 7'h00;
// Saturates so a long quiet spell cannot wrap into a false match,
// yet every new declaration restarts the count from one
always_ff @(posedge core_clk_in)
	if (reset_in)
		since <= 7'h7F;
	else if (overload_event_out)
		since <= 7'h01;
	else if (since != 7'h7F)
		since <= since + 7'h01;
////////////////////////////////////////////////////////////////////////////////
property p_declare;
	!$past(mod_reset_out) |-> (window_count_out > WIN_LIMIT) == overload_event_out;
endproperty
a_declare: assert property (p_declare) else $error("declaration disagrees with window");
property p_reset;
	overload_event_out |-> mod_reset_out && !samples_valid_out;
endproperty
a_reset: assert property (p_reset) else $error("loop reset missing");
property p_boost;
	overload_event_out |-> atten_out == {1'b0, $past(atten_prog_in)} + ATT_BOOST_DB;
endproperty
a_boost: assert property (p_boost) else $error("boost wrong");
property p_hold;
	$fell(mod_reset_out) |-> held == 7'h10;
endproperty
a_hold: assert property (p_hold) else $error("reset length wrong");
property p_ramp;
	disable iff (reset_in || overload_event_out)
	$fell(mod_reset_out) |-> atten_out == {1'b0, atten_prog_in} + ATT_BOOST_DB
		##8 atten_out == {1'b0, atten_prog_in} + 6'h05 ##40 atten_out == {1'b0, atten_prog_in};
endproperty
a_ramp: assert property (p_ramp) else $error("ramp wrong");
property p_pulse;
	overload_event_out |=> !overload_event_out;
endproperty
a_pulse: assert property (p_pulse) else $error("event not one pulse");
property p_valid;
	// A block reset also raises the flag; that return is not a recovery
	$rose(samples_valid_out) && !$past(reset_in) |-> since == VALID_CYCLES;
endproperty
a_valid: assert property (p_valid) else $error("valid return time wrong");
property p_affect;
	!samples_valid_out |-> decim_affected_out;
endproperty
a_affect: assert property (p_affect) else $error("affected flag low too early");
property p_clear;
	mod_reset_out [*3] |=> window_count_out == CNT_RESET;
endproperty
a_clear: assert property (p_clear) else $error("window not cleared");
c_event: cover property (overload_event_out);
c_rerun: cover property (overload_event_out && $past(decim_affected_out));
c_valid: cover property ($rose(samples_valid_out));
endmodule

/* quant_source_model.sv */
`timescale 1ns/1ps
module quant_source_model
	import ovl_recovery_pkg::*;
(
	// Clock and drive
	input wire logic core_clk_in,
	input wire logic overdrive_in,
	input wire logic mod_reset_in,
	// Quantizer
	output logic [QCODE_W-1:0] quant_code_out
);
logic phase = 1'b0; // Swings the code every cycle, like a real loop
// A zeroed loop settles to mid codes; overdrive clips to either extreme
always @(posedge core_clk_in)
begin
	phase <= #1 ~phase;
	if (mod_reset_in || !overdrive_in)
		quant_code_out <= #1 phase ? 5'h0F : 5'h10;
	else
		quant_code_out <= #1 phase ? FS_POS_CODE : FS_NEG_CODE;
end
endmodule

/* sigma_delta_overload_recovery_tb_top.sv */
`timescale 1ns/1ps
module sigma_delta_overload_recovery_tb_top;
import ovl_recovery_pkg::*;
logic core_clk_in = 1'b0;
logic reset_in = 1'b1;
logic overdrive = 1'b0; // Pushes the model into clipping
logic [PROG_W-1:0] prog = 5'h03;
logic [DSEL_W-1:0] dsel = 2'h0;
wire logic [QCODE_W-1:0] code;
logic mod_reset_out, overload_event_out, samples_valid_out, decim_affected_out;
logic [ATT_W-1:0] atten_out;
logic [CNT_W-1:0] window_count_out;
int fails = 0;
int check_count = 0;
int ev_n = 0; // Declarations seen
logic [11:0] fl [4] = '{12'h300, 12'h400, 12'h600, 12'h800};
initial forever #12.5 core_clk_in = ~core_clk_in;
always @(posedge core_clk_in) if (overload_event_out === 1'b1) ev_n++;
quant_source_model u_src (.core_clk_in(core_clk_in), .overdrive_in(overdrive),
	.mod_reset_in(mod_reset_out), .quant_code_out(code));
sigma_delta_overload_recovery u_dut (.core_clk_in(core_clk_in), .reset_in(reset_in),
	.quant_code_in(code), .atten_prog_in(prog), .decimation_factor_select_in(dsel),
	.mod_reset_out(mod_reset_out), .atten_out(atten_out),
	.overload_event_out(overload_event_out), .samples_valid_out(samples_valid_out),
	.decim_affected_out(decim_affected_out), .window_count_out(window_count_out));
////////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [11:0] seen, input logic [11:0] exp);
	check_count++;
	if (seen !== exp)
	begin
		fails++;
		$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
	end
endtask
// Inputs move just after the edge, so the design never races them
task automatic step;
	@(posedge core_clk_in);
	#1;
endtask
task automatic print_verdict;
	$display("checks %0d mismatches %0d", check_count, fails);
	if (fails == 0 && check_count > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
// Bounded wait; a hang counts as a mismatch and ends the run
task automatic wait_for(input int which, input int lim, output int n);
	n = 0;
	while (((which == 0) ? overload_event_out !== 1'b1 : (which == 1) ? mod_reset_out === 1'b1
		: (which == 2) ? samples_valid_out !== 1'b1 : decim_affected_out === 1'b1) && n < lim)
	begin
		step();
		n++;
	end
	if (n >= lim)
	begin
		fails++;
		print_verdict();
	end
endtask
task automatic drive(input logic [7:0] p);
	int base;
	base = ev_n;
	for (int i = 7; i >= 0; i--)
	begin
		overdrive = p[i];
		step();
	end
	overdrive = 1'b0;
	repeat (12) step();
	check(12'(ev_n - base), 12'($countones(p) > 5));
endtask
////////////////////////////////////////////////////////////////////////////////
// One full recovery; lengths come from the reset, ramp and flush figures
task automatic s_recovery(input logic [1:0] sel);
	int r, v, a;
	dsel = sel;
	overdrive = 1'b1;
	wait_for(0, 64, r);
	overdrive = 1'b0;
	check({6'h00, atten_out}, 12'(prog) + 12'h006);
	wait_for(1, 100, r);
	check(12'(r), 12'h010);
	wait_for(2, 100, v);
	check(12'(r + v), 12'h040);
	check({6'h00, atten_out}, 12'(prog));
	wait_for(3, 3000, a);
	check(12'(a), fl[sel]);
endtask
// Lasting overload must keep declaring, restarting the sequence each time
task automatic s_rerun;
	int base, n;
	base = ev_n;
	overdrive = 1'b1;
	repeat (200) step();
	overdrive = 1'b0;
	check(12'(ev_n - base > 4), 12'h001);
	wait_for(3, 3000, n);
endtask
// A reset in the middle of a ramp returns everything to rest
task automatic s_midreset;
	int n;
	overdrive = 1'b1;
	wait_for(0, 64, n);
	overdrive = 1'b0;
	repeat (30) step();
	reset_in = 1'b1;
	step();
	check({5'h00, mod_reset_out, samples_valid_out, decim_affected_out, window_count_out},
		12'h020);
	check({6'h00, atten_out}, 12'h000);
	reset_in = 1'b0;
	step();
	step();
	check({6'h00, atten_out}, 12'(prog));
endtask
////////////////////////////////////////////////////////////////////////////////
initial
begin
	repeat (20) step();
	reset_in = 1'b0;
	step();
	drive(8'hB5);
	drive(8'hDD);
	s_midreset();
	for (int s = 0; s < 4; s++) s_recovery(2'(s));
	s_rerun();
	print_verdict();
end
endmodule
bind sigma_delta_overload_recovery sdor_monitor u_mon (.core_clk_in(core_clk_in),
	.reset_in(reset_in), .quant_code_in(quant_code_in), .atten_prog_in(atten_prog_in),
	.decimation_factor_select_in(decimation_factor_select_in), .atten_out(atten_out),
	.mod_reset_out(mod_reset_out), .overload_event_out(overload_event_out),
	.samples_valid_out(samples_valid_out), .decim_affected_out(decim_affected_out),
	.window_count_out(window_count_out));
